// *** inc/boot_cfg_pkg.sv ***
// constants for boot selection and lock configuration
package boot_cfg_pkg;
  localparam int          CFG_WORDS        = 8;
  localparam int          CFG_AW           = 3;
  // extra flash array word indices
  localparam logic [2:0]  IDX_VECTOR       = 3'h0;
  localparam logic [2:0]  IDX_FUSE_COPY    = 3'h1;
  localparam logic [2:0]  IDX_BOOT_STATE   = 3'h2;
  localparam logic [2:0]  IDX_SOFT_LOCK    = 3'h3;
  localparam logic [2:0]  IDX_ID0          = 3'h4;
  localparam logic [2:0]  IDX_ID3          = 3'h7;
  // factory fuse byte fields
  localparam int          FUSE_DOUBLE_SPEED = 7;
  localparam int          FUSE_LOADER_JUMP  = 6;
  localparam int          FUSE_AUX_RAM      = 3;
  localparam int          FUSE_LOCK_MSB     = 2;
  // soft lock byte fields
  localparam int          LOCK_BIT_LOW     = 0;
  localparam int          LOCK_BIT_HIGH    = 1;
  localparam logic [7:0]  LOCK_RSVD_MASK   = 8'hFC;
  // reset and default values
  localparam logic [7:0]  FUSE_DEFAULT     = 8'hA8;
  localparam logic [7:0]  FUSE_COPY_DEF    = 8'hAB;
  localparam logic [7:0]  VECTOR_DEFAULT   = 8'hFC;
  localparam logic [7:0]  BOOT_STATE_DEF   = 8'hFF;
  localparam logic [7:0]  SOFT_LOCK_DEF    = 8'hFF;
  localparam logic [7:0]  BOOT_STATE_APP   = 8'h00;
  // boot addresses and service entry
  localparam logic [15:0] APP_START        = 16'h0000;
  localparam logic [15:0] ROM_LOADER_START = 16'hF800;
  localparam logic [15:0] SERVICE_ENTRY    = 16'hFFF0;
  localparam logic [7:0]  LOADER_LOW_BYTE  = 8'h00;
  // write path identifiers
  localparam logic [1:0]  PATH_PARALLEL    = 2'h0;
  localparam logic [1:0]  PATH_ISP         = 2'h1;
  localparam logic [1:0]  PATH_API         = 2'h2;
  // boot selection states
  typedef enum logic [2:0] {
    ST_HOLD   = 3'b001,
    ST_DECIDE = 3'b010,
    ST_RUN    = 3'b100
  } boot_state_e;
endpackage : boot_cfg_pkg

// *** core/cfg_store.sv ***
// small configuration byte store with registered read data
`timescale 1ns/1ns
module cfg_store
  import boot_cfg_pkg::*;
#(
  parameter logic [7:0] ID0 = 8'h11, // arbitrary identity value
  parameter logic [7:0] ID1 = 8'h22, // arbitrary identity value
  parameter logic [7:0] ID2 = 8'h33, // arbitrary identity value
  parameter logic [7:0] ID3 = 8'h44  // arbitrary identity value
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [CFG_AW-1:0] wr_idx,
  input  wire logic [7:0]        wr_data,
  input  wire logic              erase,
  input  wire logic [CFG_AW-1:0] rd_idx,
  output logic      [7:0]        rd_data,
  output logic      [7:0]        vector,
  output logic      [7:0]        boot_state,
  output logic      [7:0]        soft_lock
);
  logic [7:0] mem [0:3];
  logic [7:0] fuse_copy;

  // writable words; identity words fixed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= VECTOR_DEFAULT;
      mem[1] <= FUSE_COPY_DEF;
      mem[2] <= BOOT_STATE_DEF;
      mem[3] <= SOFT_LOCK_DEF;
    end else if (erase) begin
      mem[0] <= VECTOR_DEFAULT;
      mem[2] <= BOOT_STATE_DEF;
      mem[3] <= SOFT_LOCK_DEF;
    end else if (wr_en && wr_idx < IDX_ID0) begin
      mem[wr_idx[1:0]] <= wr_data;
    end
  end

  assign fuse_copy  = mem[1];
  assign vector     = mem[0];
  assign boot_state = mem[2];
  assign soft_lock  = mem[3];

  // registered read port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_idx)
        3'h4:    rd_data <= ID0;
        3'h5:    rd_data <= ID1;
        3'h6:    rd_data <= ID2;
        3'h7:    rd_data <= ID3;
        3'h1:    rd_data <= fuse_copy;
        default: rd_data <= mem[rd_idx[1:0]];
      endcase
    end
  end
endmodule : cfg_store

// *** core/boot_select_and_lock_config.sv ***
// boot source selection, fuse byte and software lock gating
`timescale 1ns/1ns
module boot_select_and_lock_config
  import boot_cfg_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // pins, forcing levels captured at the first clock edge after reset release
  input  wire logic              ext_access_pin,
  input  wire logic              prog_strobe_pin_in,
  output logic                   prog_strobe_pin_out,
  output logic                   prog_strobe_pin_oe_n,
  // configuration write port, shared by the three paths
  input  wire logic              cfg_wr,
  input  wire logic [1:0]        cfg_path,
  input  wire logic              cfg_fuse_sel,
  input  wire logic [CFG_AW-1:0] cfg_idx,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic              cfg_rd,
  input  wire logic              chip_erase,
  output logic      [7:0]        cfg_rdata,
  output logic                   cfg_rvalid,
  output logic                   cfg_refused,
  // isp flash access requests
  input  wire logic              isp_prog_req,
  input  wire logic              isp_verify_req,
  output logic                   isp_prog_grant,
  output logic                   isp_verify_grant,
  output logic                   isp_deny,
  // boot result
  output logic                   boot_valid,
  output logic      [15:0]       boot_addr,
  output logic                   boot_in_loader,
  output logic                   fetch_external,
  output logic      [15:0]       service_entry,
  output logic      [7:0]        fuse_byte,
  output logic                   double_speed_n,
  output logic                   aux_ram_n
);
  boot_state_e  state;
  boot_state_e  next_state;
  logic         forced;
  logic         fuse_set;
  logic [7:0]   fuse;
  logic [7:0]   vector;
  logic [7:0]   boot_state;
  logic [7:0]   soft_lock;
  logic [7:0]   store_rdata;
  logic         rd_pend;
  logic         rd_refused;

  // forcing pin capture: first clocked edge after release of reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuse_set <= 1'b0;
      forced   <= 1'b0;
    end else if (!fuse_set) begin
      fuse_set <= 1'b1;
      forced   <= ext_access_pin && !prog_strobe_pin_in;
    end
  end

  // lock field decode
  wire lock_low     = soft_lock[LOCK_BIT_LOW];
  wire lock_high    = soft_lock[LOCK_BIT_HIGH];
  wire level_free   = lock_low && lock_high;
  wire block_prog   = !level_free;
  wire block_verify = !lock_high;

  // write gating per path
  wire path_isp     = (cfg_path == PATH_ISP);
  wire path_api     = (cfg_path == PATH_API);
  wire path_par     = (cfg_path == PATH_PARALLEL);
  wire lock_target  = (cfg_idx == IDX_SOFT_LOCK);
  wire rsvd_clear   = lock_target &&
                      ((cfg_wdata & LOCK_RSVD_MASK) != LOCK_RSVD_MASK);
  wire isp_locked   = path_isp && block_prog && !lock_target;
  wire fuse_ok      = path_par || path_api;
  wire fuse_wr      = cfg_wr && cfg_fuse_sel && (path_par || path_api);
  wire fuse_bad     = cfg_wr && cfg_fuse_sel && path_isp;
  wire byte_wr      = cfg_wr && !cfg_fuse_sel && !rsvd_clear &&
                      !isp_locked && (cfg_idx < IDX_ID0);
  wire wr_refused   = cfg_wr && !cfg_fuse_sel &&
                      (rsvd_clear || isp_locked || cfg_idx >= IDX_ID0);
  wire rd_block     = path_isp && block_verify && cfg_rd;

  // hardware fuse byte, parallel lock field only from parallel path
  wire [7:0] api_fuse = {fuse[7], cfg_wdata[FUSE_LOADER_JUMP], fuse[5:0]};
  wire [7:0] next_fuse = path_par ? cfg_wdata : api_fuse;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuse <= FUSE_DEFAULT;
    end else if (fuse_wr && fuse_ok) begin
      fuse <= next_fuse;
    end
  end

  cfg_store u_store (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_en      (byte_wr),
    .wr_idx     (cfg_idx),
    .wr_data    (cfg_wdata),
    .erase      (chip_erase),
    .rd_idx     (cfg_idx),
    .rd_data    (store_rdata),
    .vector     (vector),
    .boot_state (boot_state),
    .soft_lock  (soft_lock)
  );

  // read response: two cycles after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend    <= 1'b0;
      rd_refused <= 1'b0;
    end else begin
      rd_pend    <= cfg_rd;
      rd_refused <= rd_block;
    end
  end

  wire [7:0] next_rdata = rd_refused ? 8'h00 :
                          (cfg_fuse_sel ? fuse : store_rdata);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata   <= 8'h00;
      cfg_rvalid  <= 1'b0;
      cfg_refused <= 1'b0;
    end else begin
      cfg_rdata   <= rd_pend ? next_rdata : 8'h00;
      cfg_rvalid  <= rd_pend;
      cfg_refused <= wr_refused || fuse_bad || (rd_pend && rd_refused);
    end
  end

  // isp flash access grants
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      isp_prog_grant   <= 1'b0;
      isp_verify_grant <= 1'b0;
      isp_deny         <= 1'b0;
    end else begin
      isp_prog_grant   <= isp_prog_req && !block_prog;
      isp_verify_grant <= isp_verify_req && !block_verify;
      isp_deny         <= (isp_prog_req && block_prog) ||
                          (isp_verify_req && block_verify);
    end
  end

  // boot address choice
  wire loader_path  = forced || !fuse[FUSE_LOADER_JUMP];
  wire stay_loader  = forced || (boot_state != BOOT_STATE_APP);
  wire custom       = !forced && (vector != VECTOR_DEFAULT);
  wire [15:0] loader_addr = custom ? {vector, LOADER_LOW_BYTE}
                                   : ROM_LOADER_START;
  wire [15:0] next_addr = (loader_path && stay_loader) ? loader_addr
                                                       : APP_START;

  // selection sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:   next_state = fuse_set ? ST_DECIDE : ST_HOLD;
      ST_DECIDE: next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // boot result outputs latched once, fetch_external follows the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_valid     <= 1'b0;
      boot_addr      <= APP_START;
      boot_in_loader <= 1'b0;
      fetch_external <= 1'b0;
    end else if (state == ST_DECIDE) begin
      boot_valid     <= 1'b1;
      boot_addr      <= next_addr;
      boot_in_loader <= loader_path && stay_loader;
      fetch_external <= !ext_access_pin;
    end else if (state == ST_RUN) begin
      fetch_external <= !ext_access_pin;
    end
  end

  // strobe pin released during reset, driven high after selection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_strobe_pin_out  <= 1'b1;
      prog_strobe_pin_oe_n <= 1'b1;
    end else begin
      prog_strobe_pin_out  <= 1'b1;
      prog_strobe_pin_oe_n <= (state != ST_RUN);
    end
  end

  // fuse fields and fixed service entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      service_entry  <= SERVICE_ENTRY;
      fuse_byte      <= FUSE_DEFAULT;
      double_speed_n <= 1'b1;
      aux_ram_n      <= 1'b1;
    end else begin
      service_entry  <= SERVICE_ENTRY;
      fuse_byte      <= fuse;
      double_speed_n <= fuse[FUSE_DOUBLE_SPEED];
      aux_ram_n      <= fuse[FUSE_AUX_RAM];
    end
  end
endmodule : boot_select_and_lock_config

// *** verif/strobe_host.sv ***
// programmer side model driving the boot forcing strobe pin
`timescale 1ns/1ns
module strobe_host (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic force_low,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_wire
);
  logic released;
  // let go of the strobe at the first edge after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) released <= 1'b0;
    else released <= 1'b1;
  end
  // wire level: device drive, else host low, else pull-up
  assign pin_wire = !pin_oe_n ? pin_out : !(force_low && !released);
endmodule : strobe_host

// *** verif/boot_select_and_lock_config_props.sv ***
// port assertions for the boot selection and lock block
`timescale 1ns/1ns
module boot_cfg_props
  import boot_cfg_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        ext_access_pin,
  input wire logic        prog_strobe_pin_oe_n,
  input wire logic        cfg_rd,
  input wire logic        cfg_rvalid,
  input wire logic        isp_prog_req,
  input wire logic        isp_prog_grant,
  input wire logic        boot_valid,
  input wire logic [15:0] boot_addr,
  input wire logic        fetch_external,
  input wire logic [15:0] service_entry,
  input wire logic [7:0]  fuse_byte,
  input wire logic        double_speed_n,
  input wire logic        aux_ram_n
);
  logic [2:0] cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // edges since reset release, saturating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 3'h0;
    else if (cnt != 3'h4) cnt <= cnt + 3'h1;
  end
  a_entry_fixed: assert property (service_entry == SERVICE_ENTRY)
    else $error("service entry wrong");
  a_boot_not_early: assert property (cnt < 3'h3 |-> !boot_valid)
    else $error("boot result too early");
  a_boot_on_time: assert property (cnt == 3'h3 |-> boot_valid)
    else $error("boot result missing");
  a_boot_holds: assert property (boot_valid |=>
    boot_valid && $stable(boot_addr)) else $error("boot result moved");
  a_low_byte_zero: assert property (boot_valid |->
    boot_addr[7:0] == LOADER_LOW_BYTE) else $error("boot low byte");
  a_fetch_pin: assert property (boot_valid && $stable(ext_access_pin)
    |-> fetch_external == !ext_access_pin) else $error("fetch source");
  a_strobe_held: assert property (!boot_valid |-> prog_strobe_pin_oe_n)
    else $error("strobe driven early");
  a_strobe_drive: assert property ($rose(boot_valid) |=>
    !prog_strobe_pin_oe_n) else $error("strobe not driven");
  a_read_answer: assert property (cfg_rd |-> ##[1:2] cfg_rvalid)
    else $error("read not answered");
  a_grant_cause: assert property (isp_prog_grant |-> $past(isp_prog_req))
    else $error("grant without request");
  a_fuse_fields: assert property ($stable(fuse_byte) |->
    double_speed_n == fuse_byte[FUSE_DOUBLE_SPEED] &&
    aux_ram_n == fuse_byte[FUSE_AUX_RAM]) else $error("fuse fields");
endmodule : boot_cfg_props
bind boot_select_and_lock_config boot_cfg_props u_props (.*);

// *** verif/tb_boot_select_and_lock_config.sv ***
// self-checking bench for boot selection and lock configuration
`timescale 1ns/1ns
module tb_boot_select_and_lock_config
  import boot_cfg_pkg::*;
;
  typedef struct packed {
    logic w; logic [1:0] p; logic f; logic [2:0] i;
    logic [7:0] d; logic [7:0] e; logic r;
  } row_s;
  logic clk_sys, rst_n, ext_access_pin, force_low, cfg_wr, cfg_fuse_sel;
  logic cfg_rd, chip_erase, isp_prog_req, isp_verify_req;
  logic [1:0] cfg_path;
  logic [CFG_AW-1:0] cfg_idx;
  logic [7:0] cfg_wdata, cfg_rdata, fuse_byte;
  logic [15:0] boot_addr, service_entry;
  logic prog_strobe_pin_in, prog_strobe_pin_out, prog_strobe_pin_oe_n;
  logic cfg_rvalid, cfg_refused, isp_prog_grant, isp_verify_grant, isp_deny;
  logic boot_valid, boot_in_loader, fetch_external, double_speed_n, aux_ram_n;
  int failures = 0;
  int comparisons = 0;
  localparam row_s ROWS [10] = '{
    '{1'b0, PATH_PARALLEL, 1'b0, IDX_VECTOR, 8'h00, 8'hFC, 1'b0},
    '{1'b0, PATH_PARALLEL, 1'b0, IDX_FUSE_COPY, 8'h00, 8'hAB, 1'b0},
    '{1'b0, PATH_API, 1'b0, IDX_SOFT_LOCK, 8'h00, 8'hFF, 1'b0},
    '{1'b1, PATH_PARALLEL, 1'b1, IDX_VECTOR, 8'h55, 8'h55, 1'b0},
    '{1'b1, PATH_API, 1'b1, IDX_VECTOR, 8'h00, 8'h15, 1'b0},
    '{1'b1, PATH_ISP, 1'b1, IDX_VECTOR, 8'hFF, 8'h15, 1'b1},
    '{1'b1, PATH_PARALLEL, 1'b0, IDX_ID0, 8'h22, 8'h00, 1'b1},
    '{1'b1, PATH_ISP, 1'b0, IDX_SOFT_LOCK, 8'h7F, 8'h00, 1'b1},
    '{1'b1, PATH_ISP, 1'b0, IDX_VECTOR, 8'hA5, 8'h00, 1'b0},
    '{1'b0, PATH_ISP, 1'b0, IDX_VECTOR, 8'h00, 8'hA5, 1'b0}};
  // device under test and strobe pin partner
  boot_select_and_lock_config u_dut (.*);
  strobe_host u_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .force_low(force_low), .pin_out(prog_strobe_pin_out),
    .pin_oe_n(prog_strobe_pin_oe_n), .pin_wire(prog_strobe_pin_in));
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // one config access, then result and refusal compare
  task automatic run(input row_s x);
    logic [7:0] q;
    logic r;
    q = 8'h00;
    r = 1'b0;
    @(posedge clk_sys);
    cfg_wr <= x.w;
    cfg_rd <= !x.w;
    {cfg_path, cfg_fuse_sel, cfg_idx, cfg_wdata} <= {x.p, x.f, x.i, x.d};
    @(posedge clk_sys);
    {cfg_wr, cfg_rd} <= 2'b00;
    repeat (3) begin
      @(negedge clk_sys);
      r = r | (cfg_refused === 1'b1);
      if (cfg_rvalid === 1'b1) q = cfg_rdata;
    end
    if (x.w && x.f) check("fuse_byte", {8'h00, fuse_byte}, {8'h00, x.e});
    else if (!x.w) check("cfg_rdata", {8'h00, q}, {8'h00, x.e});
    check("cfg_refused", {15'h0, r}, {15'h0, x.r});
  endtask : run
  // one isp request, grants and denial collected
  task automatic ispc(input logic pv, input logic vv, input logic [2:0] e);
    logic [2:0] g;
    g = 3'h0;
    @(posedge clk_sys);
    {isp_prog_req, isp_verify_req} <= {pv, vv};
    @(posedge clk_sys);
    {isp_prog_req, isp_verify_req} <= 2'b00;
    repeat (2) begin
      @(negedge clk_sys);
      g = g | {isp_prog_grant, isp_verify_grant, isp_deny};
    end
    check("isp_answer", {13'h0, g}, {13'h0, e});
  endtask : ispc
  // reset with chosen pin levels, then boot result compare
  task automatic boot(input logic ea, input logic frc);
    @(posedge clk_sys);
    {rst_n, ext_access_pin, force_low} <= {1'b0, ea, frc};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) if (boot_valid !== 1'b1) @(negedge clk_sys);
    check("boot_valid", {15'h0, boot_valid}, 16'h0001);
    check("boot_addr", boot_addr, ROM_LOADER_START);
    check("in_loader", {15'h0, boot_in_loader}, 16'h0001);
    check("fetch_ext", {15'h0, fetch_external}, {15'h0, !ea});
    check("fuse_byte", {8'h00, fuse_byte}, 16'h00A8);
    $display("boot test done");
  endtask : boot
  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    {cfg_wr, cfg_rd, cfg_fuse_sel, chip_erase} = 4'h0;
    {isp_prog_req, isp_verify_req, force_low} = 3'h0;
    {rst_n, ext_access_pin, cfg_path, cfg_idx, cfg_wdata} = 15'h1000;
    boot(1'b1, 1'b0);
    for (int k = 0; k < 10; k++) run(ROWS[k]);
    $display("table test done");
    ispc(1'b1, 1'b0, 3'b100);
    ispc(1'b0, 1'b1, 3'b010);
    run('{1'b1, PATH_API, 1'b0, IDX_BOOT_STATE, 8'h00, 8'h00, 1'b0});
    run('{1'b1, PATH_ISP, 1'b0, IDX_SOFT_LOCK, 8'hFE, 8'h00, 1'b0});
    run('{1'b1, PATH_ISP, 1'b0, IDX_VECTOR, 8'h5A, 8'h00, 1'b1});
    ispc(1'b1, 1'b0, 3'b001);
    ispc(1'b0, 1'b1, 3'b010);
    run('{1'b1, PATH_ISP, 1'b0, IDX_SOFT_LOCK, 8'hFC, 8'h00, 1'b0});
    run('{1'b0, PATH_ISP, 1'b0, IDX_VECTOR, 8'h00, 8'h00, 1'b1});
    run('{1'b0, PATH_PARALLEL, 1'b0, IDX_VECTOR, 8'h00, 8'hA5, 1'b0});
    ispc(1'b0, 1'b1, 3'b001);
    $display("lock test done");
    @(posedge clk_sys);
    chip_erase <= 1'b1;
    @(posedge clk_sys);
    chip_erase <= 1'b0;
    run('{1'b0, PATH_PARALLEL, 1'b0, IDX_SOFT_LOCK, 8'h00, 8'hFF, 1'b0});
    run('{1'b0, PATH_API, 1'b0, IDX_VECTOR, 8'h00, 8'hFC, 1'b0});
    ispc(1'b1, 1'b0, 3'b100);
    $display("erase test done");
    boot(1'b1, 1'b1);
    boot(1'b0, 1'b1);
    end_of_test();
  end
endmodule : tb_boot_select_and_lock_config
